/* File: dst_changeover.sv */
/*
  Calendar clock with daylight-saving changeover.
  Assumes minute_tick_in is a one-cycle pulse from logic on core_clk_in;
  configuration and settings arrive as plain ports with write strobes.
*/
module dst_changeover
  import dst_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       minute_tick_in,
  input  wire logic       set_wr_in,
  input  wire dst_cal_t   set_cal_in,
  input  wire logic       set_summer_in,
  input  wire logic       cfg_wr_in,
  input  wire dst_mode_t  cfg_mode_in,
  input  wire dst_point_t cfg_manual_start_in,
  input  wire dst_point_t cfg_manual_end_in,
  input  wire dst_rule_t  cfg_rule_in,
  output dst_cal_t        cal_out,
  output logic            summer_out,
  output logic            shift_fwd_out,
  output logic            shift_back_out
);

  // ==========================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==========================================================
  // stored selection
  dst_mode_t  mode_reg;
  dst_point_t man_start_reg;
  dst_point_t man_end_reg;
  dst_rule_t  rule_reg;
  wire logic [2:0] cfg_shift = (cfg_rule_in.shift_amount > SHIFT_MAX) ?
                               SHIFT_MAX : cfg_rule_in.shift_amount;
  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_reg      <= DST_NONE;
      man_start_reg <= POINT_RESET;
      man_end_reg   <= POINT_RESET;
      rule_reg      <= '{POINT_RESET, POINT_RESET, SHIFT_PRESET};
    end else if (cfg_wr_in) begin
      mode_reg      <= cfg_mode_in;
      man_start_reg <= cfg_manual_start_in;
      man_end_reg   <= cfg_manual_end_in;
      rule_reg      <= '{cfg_rule_in.start_pt, cfg_rule_in.end_pt,
                         cfg_shift};
    end
  end

  // ==========================================================
  // active changeover points
  dst_point_t pt_start;
  dst_point_t pt_end;
  logic [2:0] shift_sel;
  always_comb begin
    pt_start  = POINT_RESET;
    pt_end    = POINT_RESET;
    shift_sel = SHIFT_PRESET;
    case (mode_reg)
      DST_EU: begin
        pt_start = EU_START;
        pt_end   = EU_END;
      end
      DST_GB: begin
        pt_start = GB_START;
        pt_end   = GB_END;
      end
      DST_US: begin
        pt_start = US_START;
        pt_end   = US_END;
      end
      DST_MANUAL: begin
        pt_start = '{OCC_FIXED, WD_SUNDAY, man_start_reg.day,
                     man_start_reg.month, MANUAL_ON_HR, 6'h00};
        pt_end   = '{OCC_FIXED, WD_SUNDAY, man_end_reg.day,
                     man_end_reg.month, MANUAL_OFF_HR, 6'h00};
      end
      DST_RULE: begin
        pt_start  = rule_reg.start_pt;
        pt_end    = rule_reg.end_pt;
        // one amount serves both directions
        shift_sel = rule_reg.shift_amount;
      end
      default: begin
        shift_sel = 3'h0;
      end
    endcase
  end

  // ==========================================================
  // calendar increment, field by field
  dst_cal_t   cal_reg;
  dst_cal_t   inc;
  logic       new_day;
  wire logic [4:0] dim_cur = dst_dim(cal_reg.month, cal_reg.year);
  always_comb begin
    inc     = cal_reg;
    new_day = 1'b0;
    if (cal_reg.minute != MINUTE_LAST) begin
      inc.minute = cal_reg.minute + 6'h01;
    end else begin
      inc.minute = 6'h00;
      if (cal_reg.hour != HOUR_LAST) begin
        inc.hour = cal_reg.hour + 5'h01;
      end else begin
        inc.hour    = 5'h00;
        new_day     = 1'b1;
        inc.weekday = (cal_reg.weekday == WD_COUNT - 3'h1) ?
                      3'h0 : cal_reg.weekday + 3'h1;
        if (cal_reg.day != dim_cur) begin
          inc.day = cal_reg.day + 5'h01;
        end else begin
          inc.day = 5'h01;
          if (cal_reg.month != MONTH_LAST) begin
            inc.month = cal_reg.month + 4'h1;
          end else begin
            inc.month = 4'h1;
            inc.year  = (cal_reg.year == YEAR_LAST) ?
                        7'h00 : cal_reg.year + 7'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // changeover detection on the incremented time
  logic start_day;
  logic end_day;
  wire logic [4:0] dim_inc = dst_dim(inc.month, inc.year);
  dst_occ_match u_start_match (
    .month_in   (inc.month),
    .day_in     (inc.day),
    .weekday_in (inc.weekday),
    .dim_in     (dim_inc),
    .point_in   (pt_start),
    .hit_out    (start_day)
  );
  dst_occ_match u_end_match (
    .month_in   (inc.month),
    .day_in     (inc.day),
    .weekday_in (inc.weekday),
    .dim_in     (dim_inc),
    .point_in   (pt_end),
    .hit_out    (end_day)
  );

  logic summer_reg;
  logic start_done_reg;
  logic end_done_reg;
  // codes past the last preset decode to nothing and must never shift
  wire logic active   = (mode_reg != DST_NONE) &&
                        (mode_reg <= DST_RULE);
  wire logic at_start = start_day && inc.hour == pt_start.hour &&
                        inc.minute == pt_start.minute;
  wire logic at_end   = end_day && inc.hour == pt_end.hour &&
                        inc.minute == pt_end.minute;
  // the done flags stop the repeated hour from firing again
  wire logic do_start = minute_tick_in && active && !summer_reg &&
                        !start_done_reg && at_start;
  wire logic do_end   = minute_tick_in && active && summer_reg &&
                        !end_done_reg && at_end;

  // shift arithmetic in minutes of the day; no date carry, since
  // changeovers sit well away from midnight
  wire logic [10:0] inc_min = dst_to_min(inc.hour, inc.minute);
  wire logic [10:0] sh_min  = 11'({8'h00, shift_sel} * MIN_PER_SHIFT);
  wire logic [10:0] fwd_raw = inc_min + sh_min;
  wire logic [10:0] fwd_min = (fwd_raw >= MIN_PER_DAY) ?
                              fwd_raw - MIN_PER_DAY : fwd_raw;
  wire logic [10:0] bwd_min = (inc_min >= sh_min) ? inc_min - sh_min :
                              inc_min + MIN_PER_DAY - sh_min;
  wire logic [10:0] new_min = do_start ? fwd_min :
                              do_end ? bwd_min : inc_min;
  wire logic [4:0]  new_hr  = 5'(new_min / MIN_PER_HOUR);
  wire logic [5:0]  new_mn  = 6'(new_min % MIN_PER_HOUR);

  // ==========================================================
  // state registers
  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cal_reg        <= CAL_RESET;
      summer_reg     <= 1'b0;
      start_done_reg <= 1'b0;
      end_done_reg   <= 1'b0;
      shift_fwd_out  <= 1'b0;
      shift_back_out <= 1'b0;
    end else if (set_wr_in) begin
      cal_reg        <= set_cal_in;
      summer_reg     <= set_summer_in;
      start_done_reg <= 1'b0;
      end_done_reg   <= 1'b0;
      shift_fwd_out  <= 1'b0;
      shift_back_out <= 1'b0;
    end else begin
      shift_fwd_out  <= do_start;
      shift_back_out <= do_end;
      if (minute_tick_in) begin
        cal_reg        <= '{inc.year, inc.month, inc.day, inc.weekday,
                            new_hr, new_mn};
        summer_reg     <= do_start ? 1'b1 : do_end ? 1'b0 : summer_reg;
        start_done_reg <= do_start | (start_done_reg & !new_day);
        end_done_reg   <= do_end | (end_done_reg & !new_day);
      end
    end
  end

  assign cal_out    = cal_reg;
  assign summer_out = summer_reg;

  // ==========================================================
  // checks
  a_reset_mode_none: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg) $rose(rst_n_reg) |-> mode_reg == DST_NONE)
    else $error("selection not none after reset");
  a_none_no_shift: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg) mode_reg == DST_NONE |-> !do_start && !do_end)
    else $error("shift with no changeover selected");
  a_eu_start_time: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg)
    (mode_reg == DST_EU && do_start && !set_wr_in) |=>
      cal_reg.hour == 5'h03 && cal_reg.minute == 6'h00 && shift_fwd_out)
    else $error("eu start did not land on 3:00");
  a_gb_end_time: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg)
    (mode_reg == DST_GB && do_end && !set_wr_in) |=>
      cal_reg.hour == 5'h01 && !summer_reg)
    else $error("gb end did not land on 1:00");
  a_us_end_time: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg)
    (mode_reg == DST_US && do_end && !set_wr_in) |=>
      cal_reg.hour == 5'h01 && cal_reg.month == 4'hb &&
      cal_reg.day <= 5'h07)
    else $error("us end misplaced");
  a_shift_range: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg) rule_reg.shift_amount <= SHIFT_MAX)
    else $error("shift amount above three hours");
  a_rule_end_back: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg)
    (mode_reg == DST_RULE && do_end && !set_wr_in) |=>
      dst_to_min(cal_reg.hour, cal_reg.minute) ==
      $past(bwd_min) && $past(sh_min) ==
      11'({8'h00, $past(rule_reg.shift_amount)} * MIN_PER_SHIFT))
    else $error("end shift differs from start shift");
  a_manual_start: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg)
    (mode_reg == DST_MANUAL && do_start && !set_wr_in) |=>
      cal_reg.hour == 5'h03 && cal_reg.day == $past(man_start_reg.day))
    else $error("manual start not at 3:00 on set day");
  a_end_once: assert property (@(posedge core_clk_in)
    disable iff (!rst_n_reg)
    (do_end && !set_wr_in) |=> end_done_reg && !do_end)
    else $error("second backward shift on one day");

endmodule

/* File: dst_pkg.sv */
/*
  Shared types, constants and the changeover-point matcher for the
  daylight-saving changeover block.
  Assumes a single core clock; all users import dst_pkg::*.
*/
// Function
// - reset selects no-changeover, clock never shifted
// - EU: last March Sunday 2->3, October 3->2
// - GB: last March Sunday 1->2, October 2->1
// - US: March 2nd Sunday 2->3, November 1st 2->1
// - rule shift 0..3 hours, half-hour steps
// - rule point: occurrence, weekday, month, time
// - end changeover reuses start shift amount
// - manual: start date 2->3, end date 3->2
// - manual dates repeat every year unchanged
// - hour, minute, day, month, year separately kept
package dst_pkg;

  // ==========================================================
  // calendar and changeover point carriers
  typedef struct packed {
    logic [6:0] year;     // years after 2000
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] weekday;  // 0 = sunday
    logic [4:0] hour;
    logic [5:0] minute;
  } dst_cal_t;

  typedef struct packed {
    logic [2:0] occ;      // fixed date, 1..4 or last
    logic [2:0] weekday;
    logic [4:0] day;      // used by fixed date only
    logic [3:0] month;
    logic [4:0] hour;
    logic [5:0] minute;
  } dst_point_t;

  typedef struct packed {
    dst_point_t start_pt;
    dst_point_t end_pt;
    logic [2:0] shift_amount;  // half hours
  } dst_rule_t;

  typedef enum logic [2:0] {
    DST_NONE, DST_MANUAL, DST_EU, DST_GB, DST_US, DST_RULE
  } dst_mode_t;

  // ==========================================================
  // constants
  localparam logic [2:0]  OCC_FIXED     = 3'h0;
  localparam logic [2:0]  OCC_LAST      = 3'h5;
  localparam logic [2:0]  WD_SUNDAY     = 3'h0;
  localparam logic [2:0]  WD_COUNT      = 3'h7;
  localparam logic [2:0]  SHIFT_MAX     = 3'h6;
  localparam logic [2:0]  SHIFT_PRESET  = 3'h2;
  localparam logic [10:0] MIN_PER_HOUR  = 11'h03c;
  localparam logic [10:0] MIN_PER_DAY   = 11'h5a0;
  localparam logic [10:0] MIN_PER_SHIFT = 11'h01e;
  localparam logic [5:0]  MINUTE_LAST   = 6'h3b;
  localparam logic [4:0]  HOUR_LAST     = 5'h17;
  localparam logic [3:0]  MONTH_LAST    = 4'hc;
  localparam logic [6:0]  YEAR_LAST     = 7'h63;
  localparam logic [4:0]  DAY_WEEK      = 5'h07;
  localparam logic [4:0]  MANUAL_ON_HR  = 5'h02;
  localparam logic [4:0]  MANUAL_OFF_HR = 5'h03;
  // power-on calendar: wednesday 1:00, 2002-05-01
  localparam dst_cal_t CAL_RESET = '{7'h02, 4'h5, 5'h01, 3'h3,
                                     5'h01, 6'h00};
  localparam dst_point_t EU_START = '{OCC_LAST, WD_SUNDAY, 5'h00,
                                      4'h3, 5'h02, 6'h00};
  localparam dst_point_t EU_END   = '{OCC_LAST, WD_SUNDAY, 5'h00,
                                      4'ha, 5'h03, 6'h00};
  localparam dst_point_t GB_START = '{OCC_LAST, WD_SUNDAY, 5'h00,
                                      4'h3, 5'h01, 6'h00};
  localparam dst_point_t GB_END   = '{OCC_LAST, WD_SUNDAY, 5'h00,
                                      4'ha, 5'h02, 6'h00};
  localparam dst_point_t US_START = '{3'h2, WD_SUNDAY, 5'h00,
                                      4'h3, 5'h02, 6'h00};
  localparam dst_point_t US_END   = '{3'h1, WD_SUNDAY, 5'h00,
                                      4'hb, 5'h02, 6'h00};
  localparam dst_point_t POINT_RESET = '{OCC_FIXED, WD_SUNDAY, 5'h01,
                                         4'h1, 5'h00, 6'h00};

  // ==========================================================
  // helpers
  function automatic logic [4:0] dst_dim(input logic [3:0] m,
                                         input logic [6:0] y);
    logic [4:0] d;
    d = 5'h1f;
    if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hb) begin
      d = 5'h1e;
    end else if (m == 4'h2) begin
      // years 2000..2099: every fourth year is a leap year
      d = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
    end
    return d;
  endfunction

  function automatic logic [10:0] dst_to_min(input logic [4:0] h,
                                             input logic [5:0] m);
    return 11'({6'h00, h} * MIN_PER_HOUR) + {5'h00, m};
  endfunction

endpackage

/*
  Combinational test: does a calendar date fall on a changeover day.
  Assumes the caller supplies the month length of the date's month.
*/
module dst_occ_match
  import dst_pkg::*;
(
  input  wire logic [3:0] month_in,
  input  wire logic [4:0] day_in,
  input  wire logic [2:0] weekday_in,
  input  wire logic [4:0] dim_in,
  input  wire dst_point_t point_in,
  output logic            hit_out
);
  wire logic [4:0] week_idx = 5'((day_in - 5'h01) / DAY_WEEK);
  wire logic       last_wk  = ({1'b0, day_in} + {1'b0, DAY_WEEK})
                              > {1'b0, dim_in};
  wire logic       nth_wk   = (week_idx == 5'(point_in.occ - 3'h1));
  wire logic       wd_hit   = (weekday_in == point_in.weekday) &&
                              ((point_in.occ == OCC_LAST) ? last_wk
                                                          : nth_wk);
  // a fixed date carries no year, so it recurs every year
  wire logic       fx_hit   = (day_in == point_in.day);
  assign hit_out = (month_in == point_in.month) &&
                   ((point_in.occ == OCC_FIXED) ? fx_hit : wd_hit);
endmodule

/* File: dst_changeover_tb_top.sv */
/*
  Self-checking bench for the daylight-saving changeover block.
  Assumes dst_pkg and dst_changeover are compiled first; no other models.
*/
module dst_changeover_tb_top
  import dst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // stimulus and observed signals
  logic       core_clk_in;
  logic       resetn_in;
  logic       minute_tick_in;
  logic       set_wr_in;
  dst_cal_t   set_cal_in;
  logic       set_summer_in;
  logic       cfg_wr_in;
  dst_mode_t  cfg_mode_in;
  dst_point_t cfg_manual_start_in;
  dst_point_t cfg_manual_end_in;
  dst_rule_t  cfg_rule_in;
  dst_cal_t   cal_out;
  logic       summer_out;
  logic       shift_fwd_out;
  logic       shift_back_out;
  int         errors;
  int         checks;
  int         cycles;

  dst_changeover dst_changeover_inst (
    .core_clk_in         (core_clk_in),
    .resetn_in           (resetn_in),
    .minute_tick_in      (minute_tick_in),
    .set_wr_in           (set_wr_in),
    .set_cal_in          (set_cal_in),
    .set_summer_in       (set_summer_in),
    .cfg_wr_in           (cfg_wr_in),
    .cfg_mode_in         (cfg_mode_in),
    .cfg_manual_start_in (cfg_manual_start_in),
    .cfg_manual_end_in   (cfg_manual_end_in),
    .cfg_rule_in         (cfg_rule_in),
    .cal_out             (cal_out),
    .summer_out          (summer_out),
    .shift_fwd_out       (shift_fwd_out),
    .shift_back_out      (shift_back_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // shared tasks
  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // roughly 280 cycles are needed; the ceiling leaves wide margin
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic dst_cal_t mk(input int y, input int mo, input int d,
                                  input int wd, input int h, input int mi);
    return '{7'(y), 4'(mo), 5'(d), 3'(wd), 5'(h), 6'(mi)};
  endfunction

  task automatic configure(input dst_mode_t m, input dst_rule_t r);
    @(negedge core_clk_in);
    cfg_wr_in = 1'b1;
    cfg_mode_in = m;
    cfg_rule_in = r;
    @(negedge core_clk_in);
    cfg_wr_in = 1'b0;
  endtask

  // set then tick; results are looked at a half cycle after the tick edge
  task automatic set_and_tick(input dst_cal_t c, input logic s);
    @(negedge core_clk_in);
    set_wr_in = 1'b1;
    set_cal_in = c;
    set_summer_in = s;
    @(negedge core_clk_in);
    set_wr_in = 1'b0;
    minute_tick_in = 1'b1;
    @(negedge core_clk_in);
    minute_tick_in = 1'b0;
  endtask

  task automatic shift_case(input dst_cal_t c, input logic s, input int eh,
                            input int em, input logic es, input logic ef,
                            input logic eb);
    dst_cal_t e;
    e = c;
    e.hour = 5'(eh);
    e.minute = 6'(em);
    set_and_tick(c, s);
    check("cal_out", 64'(cal_out), 64'(e));
    check("summer_out", 64'(summer_out), 64'(es));
    check("shift_fwd_out", 64'(shift_fwd_out), 64'(ef));
    check("shift_back_out", 64'(shift_back_out), 64'(eb));
    @(negedge core_clk_in);
    check("fwd_pulse_end", 64'(shift_fwd_out), 64'h0);
    check("back_pulse_end", 64'(shift_back_out), 64'h0);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_none;
    shift_case(mk(24, 3, 31, 0, 1, 59), 1'b0, 2, 0, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic test_eu;
    logic seen;
    seen = 1'b0;
    configure(DST_EU, cfg_rule_in);
    shift_case(mk(24, 3, 24, 0, 1, 59), 1'b0, 2, 0, 1'b0, 1'b0, 1'b0);
    shift_case(mk(24, 3, 31, 0, 1, 59), 1'b0, 3, 0, 1'b1, 1'b1, 1'b0);
    shift_case(mk(24, 10, 27, 0, 2, 59), 1'b1, 2, 0, 1'b0, 1'b0, 1'b1);
    // the repeated hour must run through 3:00 without a second shift
    repeat (60) begin
      minute_tick_in = 1'b1;
      @(negedge core_clk_in);
      minute_tick_in = 1'b0;
      seen |= shift_fwd_out | shift_back_out;
      @(negedge core_clk_in);
    end
    check("repeat_hour", 64'(cal_out), 64'(mk(24, 10, 27, 0, 3, 0)));
    check("repeat_shift", 64'(seen), 64'h0);
  endtask

  task automatic test_gb;
    configure(DST_GB, cfg_rule_in);
    shift_case(mk(24, 3, 31, 0, 0, 59), 1'b0, 2, 0, 1'b1, 1'b1, 1'b0);
    shift_case(mk(24, 10, 27, 0, 1, 59), 1'b1, 1, 0, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic test_us;
    configure(DST_US, cfg_rule_in);
    shift_case(mk(24, 3, 3, 0, 1, 59), 1'b0, 2, 0, 1'b0, 1'b0, 1'b0);
    shift_case(mk(24, 3, 10, 0, 1, 59), 1'b0, 3, 0, 1'b1, 1'b1, 1'b0);
    shift_case(mk(24, 11, 3, 0, 1, 59), 1'b1, 1, 0, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic test_manual;
    cfg_manual_start_in = '{OCC_FIXED, 3'h0, 5'h0f, 4'h4, 5'h00, 6'h00};
    cfg_manual_end_in = '{OCC_FIXED, 3'h0, 5'h14, 4'h9, 5'h00, 6'h00};
    configure(DST_MANUAL, cfg_rule_in);
    shift_case(mk(24, 4, 15, 1, 1, 59), 1'b0, 3, 0, 1'b1, 1'b1, 1'b0);
    shift_case(mk(24, 9, 20, 5, 2, 59), 1'b1, 2, 0, 1'b0, 1'b0, 1'b1);
    shift_case(mk(25, 4, 15, 2, 1, 59), 1'b0, 3, 0, 1'b1, 1'b1, 1'b0);
    shift_case(mk(25, 9, 20, 6, 2, 59), 1'b1, 2, 0, 1'b0, 1'b0, 1'b1);
  endtask

  // start: first saturday of april 4:00; end: last sunday of september 10:00
  task automatic test_rule;
    dst_rule_t r;
    int        st;
    int        en;
    int        eff;
    // zero is a legal amount; seven checks the clamp to three hours
    for (int sh = 0; sh <= 7; sh++) begin
      r.start_pt = '{3'h1, 3'h6, 5'h00, 4'h4, 5'h04, 6'h00};
      r.end_pt = '{OCC_LAST, 3'h0, 5'h00, 4'h9, 5'h0a, 6'h00};
      r.shift_amount = 3'(sh);
      configure(DST_RULE, r);
      eff = (sh > int'(SHIFT_MAX)) ? int'(SHIFT_MAX) : sh;
      st = 240 + eff * 30;
      en = 600 - eff * 30;
      shift_case(mk(24, 4, 6, 6, 3, 59), 1'b0, st / 60, st % 60,
                 1'b1, 1'b1, 1'b0);
      shift_case(mk(24, 9, 29, 0, 9, 59), 1'b1, en / 60, en % 60,
                 1'b0, 1'b0, 1'b1);
    end
    shift_case(mk(24, 4, 13, 6, 3, 59), 1'b0, 4, 0, 1'b0, 1'b0, 1'b0);
    shift_case(mk(24, 9, 22, 0, 9, 59), 1'b1, 10, 0, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic test_rollover;
    set_and_tick(mk(24, 12, 31, 2, 23, 59), 1'b0);
    check("year_roll", 64'(cal_out), 64'(mk(25, 1, 1, 3, 0, 0)));
    set_and_tick(mk(24, 2, 28, 3, 23, 59), 1'b0);
    check("leap_day", 64'(cal_out), 64'(mk(24, 2, 29, 4, 0, 0)));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    resetn_in = 1'b0;
    minute_tick_in = 1'b0;
    set_wr_in = 1'b0;
    set_cal_in = CAL_RESET;
    set_summer_in = 1'b0;
    cfg_wr_in = 1'b0;
    cfg_mode_in = DST_NONE;
    cfg_manual_start_in = POINT_RESET;
    cfg_manual_end_in = POINT_RESET;
    cfg_rule_in = '{POINT_RESET, POINT_RESET, SHIFT_PRESET};
    repeat (4) @(negedge core_clk_in);
    check("reset_cal", 64'(cal_out), 64'(CAL_RESET));
    check("reset_summer", 64'(summer_out), 64'h0);
    resetn_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    test_none();
    test_eu();
    test_gb();
    test_us();
    test_manual();
    test_rule();
    test_rollover();
    finish_test();
  end
endmodule
